//--- verilog/esp_pkg.sv
// Package: widths, access kinds and carrier struct for the bus port
package esp_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int PTR_W  = 2;
    localparam logic [BE_W-1:0]  BE_DWORD  = 4'h0;
    localparam logic [BE_W-1:0]  BE_LOW    = 4'hc;
    localparam logic [BE_W-1:0]  BE_HIGH   = 4'h3;
    localparam logic [BE_W-1:0]  BE_B0     = 4'he;
    localparam logic [BE_W-1:0]  BE_B1     = 4'hd;
    localparam logic [BE_W-1:0]  BE_B2     = 4'hb;
    localparam logic [BE_W-1:0]  BE_B3     = 4'h7;
    localparam logic [BE_W-1:0]  BE_IDLE   = 4'hf;
    localparam logic [PTR_W-1:0] PTR_ONE   = 2'h1;
    localparam logic [PTR_W-1:0] PTR_FULL  = 2'h3;

    typedef enum logic [2:0] {
        K_DWORD = 3'h0,
        K_LOW   = 3'h1,
        K_HIGH  = 3'h2,
        K_B0    = 3'h3,
        K_B1    = 3'h4,
        K_B2    = 3'h5,
        K_B3    = 3'h6,
        K_BAD   = 3'h7
    } esp_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   be;
        esp_kind_t         kind;
        logic              wr;
        logic [DATA_W-1:0] wdata;
    } esp_acc_t;

    function automatic esp_kind_t be_kind(input logic [BE_W-1:0] be);
        case (be)
            BE_DWORD: return K_DWORD;
            BE_LOW:   return K_LOW;
            BE_HIGH:  return K_HIGH;
            BE_B0:    return K_B0;
            BE_B1:    return K_B1;
            BE_B2:    return K_B2;
            BE_B3:    return K_B3;
            default:  return K_BAD;
        endcase
    endfunction
endpackage

//--- verilog/esp_eisa_port.sv
// Module: 32-bit bus slave port with I/O strobes and DMA burst buffer
// How it works
// - Acts as 32-bit I/O slave on asynchronous read and write strobes.
// - I/O accesses never pull the ready line low.
// - DMA burst accepts one doubleword every bus clock while the two-entry buffer is not full.
// - A burst word is taken only while the ready line is high.
// - Address bits 2 to 15 latch on the address strobe rising edge.
// - An access decodes only while the latched qualifier is low.
// - Qualifier latch is open while strobe low, closes on its rise.
// - Write data is taken at the write strobe trailing edge.
// - Byte enables latch on the strobe rise and steer the access.
// - Interrupt output is an active high edge request.
// - Byte enable pattern selects dword, word or single byte access.
module esp_eisa_port (
    // Clocks and reset
    input  wire logic                         mclk,
    input  wire logic                         srst,
    input  wire logic                         bus_clk,
    // Bus pins
    input  wire logic                         address_strobe_low,
    input  wire logic                         io_decode_qualifier,
    input  wire logic [esp_pkg::ADDR_W-1:0]   bus_addr,
    input  wire logic [esp_pkg::BE_W-1:0]     byte_lane_enables_low,
    input  wire logic                         read_strobe_low,
    input  wire logic                         write_strobe_low,
    input  wire logic                         dma_ack_low,
    input  wire logic                         exrdy_in,
    input  wire logic [esp_pkg::DATA_W-1:0]   data_in,
    output logic      [esp_pkg::DATA_W-1:0]   data_out,
    output logic                              data_oe_n,
    output logic                              exrdy_out,
    output logic                              exrdy_oe_n,
    output logic                              interrupt_request_out,
    // Core side
    output logic                              io_req,
    output esp_pkg::esp_acc_t                 io_acc,
    input  wire logic [esp_pkg::DATA_W-1:0]   core_rdata,
    input  wire logic                         irq_event,
    // DMA stream
    output logic                              dma_valid,
    input  wire logic                         dma_ready,
    output logic      [esp_pkg::DATA_W-1:0]   dma_data,
    output logic                              link_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic                                     rst_s1;
        logic                                     rst_s2;
        logic                                     as_q;
        logic                                     aen_lat;
        logic [esp_pkg::ADDR_W-1:0]               addr;
        logic [esp_pkg::BE_W-1:0]                 be;
        logic [esp_pkg::PTR_W-1:0]                wp;
        logic [esp_pkg::PTR_W-1:0]                wg;
        logic [esp_pkg::PTR_W-1:0]                rg_s1;
        logic [esp_pkg::PTR_W-1:0]                rg_s2;
        logic [1:0][esp_pkg::DATA_W-1:0]          mem;
    } esp_link_t;

    typedef struct packed {
        logic                                     rd_s1;
        logic                                     rd_s2;
        logic                                     rd_s3;
        logic                                     wr_s1;
        logic                                     wr_s2;
        logic                                     wr_s3;
        logic                                     dk_s1;
        logic                                     dk_s2;
        logic [esp_pkg::DATA_W-1:0]               d_s1;
        logic [esp_pkg::DATA_W-1:0]               d_s2;
        logic [esp_pkg::DATA_W-1:0]               wdata;
        logic [esp_pkg::PTR_W-1:0]                wg_s1;
        logic [esp_pkg::PTR_W-1:0]                wg_s2;
        logic [esp_pkg::PTR_W-1:0]                rp;
        logic [esp_pkg::PTR_W-1:0]                rg;
        logic                                     req;
        esp_pkg::esp_acc_t                        acc;
        logic [esp_pkg::DATA_W-1:0]               dout;
        logic                                     oe_n;
        logic                                     irq;
    } esp_core_t;

    esp_link_t l_ff;
    esp_link_t nxt_l;
    esp_core_t c_ff;
    esp_core_t nxt_c;
    logic      full;
    logic      push;
    logic      empty;
    logic      reading;
    logic      rd_fall;
    logic      wr_rise;
    logic [esp_pkg::PTR_W-1:0] wp_inc;
    logic [esp_pkg::PTR_W-1:0] rp_inc;

    // ----------------------------------------
    // Link domain: address phase and burst fill
    // ----------------------------------------
    // Gray pointers keep the two-entry buffer safe across the clocks
    assign full   = (l_ff.wg == (l_ff.rg_s2 ^ esp_pkg::PTR_FULL));
    assign push   = !dma_ack_low && exrdy_in && !full;
    assign wp_inc = l_ff.wp + esp_pkg::PTR_ONE;
    assign link_ready = !full;

    always_comb
    begin
        nxt_l        = l_ff;
        nxt_l.rst_s1 = srst;
        nxt_l.rst_s2 = l_ff.rst_s1;
        nxt_l.rg_s1  = c_ff.rg;
        nxt_l.rg_s2  = l_ff.rg_s1;
        nxt_l.as_q   = address_strobe_low;
        if (!address_strobe_low)
        begin
            nxt_l.aen_lat = io_decode_qualifier;
        end
        if (address_strobe_low && !l_ff.as_q)
        begin
            nxt_l.addr = bus_addr;
            nxt_l.be   = byte_lane_enables_low;
        end
        if (push)
        begin
            // Words land whole; alignment is left to the master
            nxt_l.mem[l_ff.wp[0]] = data_in;
            nxt_l.wp = wp_inc;
            nxt_l.wg = {wp_inc[1], wp_inc[1] ^ wp_inc[0]};
        end
        if (l_ff.rst_s2)
        begin
            nxt_l.as_q    = 1'b1;
            nxt_l.aen_lat = 1'b1;
            nxt_l.addr    = '0;
            nxt_l.be      = esp_pkg::BE_IDLE;
            nxt_l.wp      = '0;
            nxt_l.wg      = '0;
            nxt_l.rg_s1   = '0;
            nxt_l.rg_s2   = '0;
            nxt_l.mem     = '0;
        end
    end

    always_ff @(posedge bus_clk)
    begin
        l_ff <= nxt_l;
    end

    // ----------------------------------------
    // Core domain: strobes, register access, drain
    // ----------------------------------------
    // Address and enables are read only after the strobe sync, so they have settled
    assign rd_fall = !c_ff.rd_s2 && c_ff.rd_s3;
    assign wr_rise = c_ff.wr_s2 && !c_ff.wr_s3;
    assign reading = !c_ff.rd_s2 && c_ff.dk_s2 && !l_ff.aen_lat;
    assign empty   = (c_ff.rg == c_ff.wg_s2);
    assign rp_inc  = c_ff.rp + esp_pkg::PTR_ONE;

    always_comb
    begin
        nxt_c       = c_ff;
        nxt_c.rd_s1 = read_strobe_low;
        nxt_c.rd_s2 = c_ff.rd_s1;
        nxt_c.rd_s3 = c_ff.rd_s2;
        nxt_c.wr_s1 = write_strobe_low;
        nxt_c.wr_s2 = c_ff.wr_s1;
        nxt_c.wr_s3 = c_ff.wr_s2;
        nxt_c.dk_s1 = dma_ack_low;
        nxt_c.dk_s2 = c_ff.dk_s1;
        nxt_c.d_s1  = data_in;
        nxt_c.d_s2  = c_ff.d_s1;
        nxt_c.wg_s1 = l_ff.wg;
        nxt_c.wg_s2 = c_ff.wg_s1;
        nxt_c.irq   = irq_event;
        nxt_c.req   = 1'b0;
        nxt_c.oe_n  = !reading;
        if (reading)
        begin
            nxt_c.dout = core_rdata;
        end
        if (!c_ff.wr_s2)
        begin
            nxt_c.wdata = c_ff.d_s2;
        end
        if ((rd_fall || wr_rise) && !l_ff.aen_lat)
        begin
            nxt_c.req        = 1'b1;
            nxt_c.acc.addr   = l_ff.addr;
            nxt_c.acc.be     = l_ff.be;
            nxt_c.acc.kind   = esp_pkg::be_kind(l_ff.be);
            nxt_c.acc.wr     = wr_rise;
            nxt_c.acc.wdata  = c_ff.wdata;
        end
        if (!empty && dma_ready)
        begin
            nxt_c.rp = rp_inc;
            nxt_c.rg = {rp_inc[1], rp_inc[1] ^ rp_inc[0]};
        end
        if (srst)
        begin
            nxt_c      = '0;
            nxt_c.rd_s1 = 1'b1;
            nxt_c.rd_s2 = 1'b1;
            nxt_c.rd_s3 = 1'b1;
            nxt_c.wr_s1 = 1'b1;
            nxt_c.wr_s2 = 1'b1;
            nxt_c.wr_s3 = 1'b1;
            nxt_c.dk_s1 = 1'b1;
            nxt_c.dk_s2 = 1'b1;
            nxt_c.oe_n  = 1'b1;
            nxt_c.acc.be   = esp_pkg::BE_IDLE;
            nxt_c.acc.kind = esp_pkg::K_BAD;
        end
    end

    always_ff @(posedge mclk)
    begin
        c_ff <= nxt_c;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Strobes outlast the sync delay, so the ready line is never driven
    assign exrdy_out             = 1'b0;
    assign exrdy_oe_n            = 1'b1;
    assign data_out              = c_ff.dout;
    assign data_oe_n             = c_ff.oe_n;
    assign interrupt_request_out = c_ff.irq;
    assign io_req                = c_ff.req;
    assign io_acc                = c_ff.acc;
    assign dma_valid             = !empty;
    assign dma_data              = l_ff.mem[c_ff.rp[0]];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_rd_sync_req: assert property (@(posedge mclk) disable iff (srst)
        (rd_fall && !l_ff.aen_lat) |=> (io_req && !io_acc.wr))
        else $error("read strobe did not raise a read request");
    chk_wr_trail_data: assert property (@(posedge mclk) disable iff (srst)
        (wr_rise && !l_ff.aen_lat) |=> (io_req && io_acc.wr && io_acc.wdata == $past(c_ff.wdata)))
        else $error("write data not taken at strobe end");
    chk_aen_blocks_req: assert property (@(posedge mclk) disable iff (srst)
        io_req |-> !$past(l_ff.aen_lat))
        else $error("request while qualifier high");
    chk_rd_drive_bus: assert property (@(posedge mclk) disable iff (srst)
        reading |=> (!data_oe_n && data_out == $past(core_rdata)))
        else $error("read data not driven");
    chk_exrdy_never_low: assert property (@(posedge mclk) disable iff (srst)
        exrdy_oe_n)
        else $error("ready line driven");
    chk_irq_edge_out: assert property (@(posedge mclk) disable iff (srst)
        $rose(irq_event) |=> $rose(interrupt_request_out))
        else $error("interrupt edge lost");
    chk_kind_from_be: assert property (@(posedge mclk) disable iff (srst)
        (io_req && io_acc.be == esp_pkg::BE_LOW) |-> io_acc.kind == esp_pkg::K_LOW)
        else $error("byte enable decode wrong");
    chk_dma_wait_hold: assert property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        !exrdy_in |=> $stable(l_ff.wp))
        else $error("burst word taken during wait");
    chk_dma_peak_rate: assert property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        push |=> (l_ff.wp == $past(wp_inc) && l_ff.mem[$past(l_ff.wp[0])] == $past(data_in)))
        else $error("burst word not stored");
    chk_be_latch_rise: assert property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        (address_strobe_low && !l_ff.as_q) |=> l_ff.be == $past(byte_lane_enables_low))
        else $error("byte enables not latched");
    chk_addr_latch_rise: assert property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        (address_strobe_low && !l_ff.as_q) ##1 address_strobe_low |=> $stable(l_ff.addr))
        else $error("address moved while strobe high");
    chk_aen_open_low: assert property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        !address_strobe_low |=> l_ff.aen_lat == $past(io_decode_qualifier))
        else $error("qualifier latch not transparent");
    chk_req_pulse: assert property (@(posedge mclk) disable iff (srst)
        io_req |=> !io_req)
        else $error("request held longer than one cycle");
    chk_write_no_drive: assert property (@(posedge mclk) disable iff (srst)
        (io_req && io_acc.wr) |-> data_oe_n)
        else $error("bus driven during a write");
    chk_dma_no_drive: assert property (@(posedge mclk) disable iff (srst)
        !c_ff.dk_s2 |=> data_oe_n)
        else $error("bus driven during a burst");
    chk_full_keeps_words: assert property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        !link_ready |=> $stable(l_ff.mem))
        else $error("buffer word overwritten while full");

    cov_io_write: cover property (@(posedge mclk) disable iff (srst) io_req && io_acc.wr);
    cov_io_read: cover property (@(posedge mclk) disable iff (srst) io_req && !io_acc.wr);
    cov_dma_full: cover property (@(posedge bus_clk) disable iff (l_ff.rst_s2)
        push ##1 push ##1 full);
    cov_dma_drain: cover property (@(posedge mclk) disable iff (srst) dma_valid && dma_ready);
    cov_io_refused: cover property (@(posedge mclk) disable iff (srst)
        (rd_fall || wr_rise) && l_ff.aen_lat);
endmodule // esp_eisa_port

//--- test/esp_bus_model.sv
// Bus side model: I/O strobe cycles and DMA bursts at the port pins
module esp_bus_model (
    // Link clock
    input  wire logic                       bus_clk,
    // Bus pins
    output logic                            address_strobe_low,
    output logic                            io_decode_qualifier,
    output logic [esp_pkg::ADDR_W-1:0]      bus_addr,
    output logic [esp_pkg::BE_W-1:0]        byte_lane_enables_low,
    output logic                            read_strobe_low,
    output logic                            write_strobe_low,
    output logic                            dma_ack_low,
    output logic                            exrdy_in,
    output logic [esp_pkg::DATA_W-1:0]      data_in,
    input  wire logic                       link_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        address_strobe_low = 1'b1;
        io_decode_qualifier = 1'b1;
        bus_addr = '0;
        byte_lane_enables_low = esp_pkg::BE_IDLE;
        read_strobe_low = 1'b1;
        write_strobe_low = 1'b1;
        dma_ack_low = 1'b1;
        exrdy_in = 1'b1;
        data_in = '0;
    end

    // ----------------------------------------
    // One I/O access
    // ----------------------------------------
    task automatic io_cycle(input logic [13:0] a, input logic [3:0] be, input logic wr,
                            input logic qual, input logic [31:0] d);
        @(posedge bus_clk);
        bus_addr <= a;
        byte_lane_enables_low <= be;
        io_decode_qualifier <= qual;
        address_strobe_low <= 1'b0;
        @(posedge bus_clk);
        address_strobe_low <= 1'b1;
        @(posedge bus_clk);
        // Pins move after the strobe rise: only latched copies may count
        io_decode_qualifier <= 1'b1;
        byte_lane_enables_low <= ~be;
        bus_addr <= ~a;
        data_in <= ~d;
        if (wr)
            write_strobe_low <= 1'b0;
        else
            read_strobe_low <= 1'b0;
        repeat (2) @(posedge bus_clk);
        data_in <= d;
        repeat (3) @(posedge bus_clk);
        write_strobe_low <= 1'b1;
        read_strobe_low <= 1'b1;
        repeat (3) @(posedge bus_clk);
        data_in <= ~d;
    endtask

    // ----------------------------------------
    // DMA burst, wait state every third cycle
    // ----------------------------------------
    task automatic dma_burst(input int n, input logic [31:0] base);
        int k;
        int c;
        k = 0;
        c = 0;
        while (k < n)
        begin
            @(posedge bus_clk);
            if (!dma_ack_low && exrdy_in && link_ready)
                k++;
            if (k < n)
            begin
                dma_ack_low <= 1'b0;
                exrdy_in <= (c % 3 != 2);
                // Whole doublewords only; a junk word rides the wait state
                data_in <= (c % 3 != 2) ? base + 32'(k) : ~(base + 32'(k));
                c++;
            end
        end
        dma_ack_low <= 1'b1;
        exrdy_in <= 1'b1;
        data_in <= ~data_in;
    endtask
endmodule // esp_bus_model

//--- test/esp_eisa_port_test.sv
// Testbench: self-checking run of the bus slave port
module esp_eisa_port_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic              mclk, srst, bus_clk, dma_ready, irq_event, drove;
    logic              asl, qual, rsl, wsl, dal, exi, link_ready;
    logic [13:0]       addr;
    logic [3:0]        be;
    logic [31:0]       din, dout, core_rdata, dma_data, last_rd, dma_base;
    logic              oe_n, exo, exo_oe_n, irq_out, io_req, dma_valid;
    esp_pkg::esp_acc_t io_acc, got_acc;
    int                errors, n_tests, got_n, pop_n, cyc;
    logic [3:0]        bes [8] = '{esp_pkg::BE_DWORD, esp_pkg::BE_LOW, esp_pkg::BE_HIGH,
                                  esp_pkg::BE_B0, esp_pkg::BE_B1, esp_pkg::BE_B2,
                                  esp_pkg::BE_B3, 4'h5};

    esp_eisa_port dut_u (.mclk(mclk), .srst(srst), .bus_clk(bus_clk),
        .address_strobe_low(asl), .io_decode_qualifier(qual), .bus_addr(addr),
        .byte_lane_enables_low(be), .read_strobe_low(rsl), .write_strobe_low(wsl),
        .dma_ack_low(dal), .exrdy_in(exi), .data_in(din), .data_out(dout),
        .data_oe_n(oe_n), .exrdy_out(exo), .exrdy_oe_n(exo_oe_n),
        .interrupt_request_out(irq_out), .io_req(io_req), .io_acc(io_acc),
        .core_rdata(core_rdata), .irq_event(irq_event), .dma_valid(dma_valid),
        .dma_ready(dma_ready), .dma_data(dma_data), .link_ready(link_ready));

    esp_bus_model model_u (.bus_clk(bus_clk), .address_strobe_low(asl),
        .io_decode_qualifier(qual), .bus_addr(addr), .byte_lane_enables_low(be),
        .read_strobe_low(rsl), .write_strobe_low(wsl), .dma_ack_low(dal),
        .exrdy_in(exi), .data_in(din), .link_ready(link_ready));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Link clock is free running with a 6 ns period, against the 4 ns core clock
    initial
    begin
        bus_clk = 1'b0;
        #1.3;
        forever #3 bus_clk = ~bus_clk;
    end

    // ----------------------------------------
    // Compare, report and monitors
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Pulses last one cycle, so they are caught here, not in the tasks
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (io_req === 1'b1)
        begin
            got_n <= got_n + 1;
            got_acc <= io_acc;
        end
        if (oe_n === 1'b0)
        begin
            drove <= 1'b1;
            last_rd <= dout;
        end
        if (dma_valid === 1'b1 && dma_ready === 1'b1)
        begin
            chk(dma_data, dma_base + 32'(pop_n));
            pop_n <= pop_n + 1;
        end
        if (cyc == 6000)
        begin
            errors++;
            stop_test;
        end
    end

    task automatic wait_req(input int n0);
        for (int i = 0; i < 20 && got_n == n0; i++)
            @(posedge mclk);
        chk(32'(got_n), 32'(n0 + 1));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_writes;
        int          n0;
        logic [13:0] a;
        logic [31:0] d;
        for (int i = 0; i < 8; i++)
        begin
            n0 = got_n;
            a = 14'h3ff0 + 14'(i);
            d = 32'hc0de_0000 + 32'(i);
            model_u.io_cycle(a, bes[i], 1'b1, 1'b0, d);
            wait_req(n0);
            chk({10'h0, got_acc.addr, got_acc.be, got_acc.kind, got_acc.wr},
                {10'h0, a, bes[i], 3'(i), 1'b1});
            chk(got_acc.wdata, d);
        end
    endtask

    task automatic t_read;
        int n0;
        n0 = got_n;
        drove = 1'b0;
        core_rdata <= 32'h5a5a_c3c3;
        model_u.io_cycle(14'h2abc, esp_pkg::BE_DWORD, 1'b0, 1'b0, 32'h0);
        wait_req(n0);
        chk({31'h0, got_acc.wr}, 32'h0);
        chk({31'h0, drove}, 32'h1);
        chk(last_rd, 32'h5a5a_c3c3);
        for (int i = 0; i < 20 && oe_n !== 1'b1; i++)
            @(posedge mclk);
        chk({29'h0, exo, oe_n, exo_oe_n}, 32'h3);
    endtask

    // A qualifier high at the strobe rise must leave the core untouched
    task automatic t_refuse;
        int n0;
        n0 = got_n;
        drove = 1'b0;
        model_u.io_cycle(14'h0011, esp_pkg::BE_DWORD, 1'b0, 1'b1, 32'h0);
        repeat (15) @(posedge mclk);
        chk(32'(got_n), 32'(n0));
        chk({31'h0, drove}, 32'h0);
    endtask

    // Sink stalls first so the buffer fills and the bus has to wait
    task automatic t_dma;
        pop_n = 0;
        dma_base = 32'h4000_0000;
        fork
            model_u.dma_burst(12, dma_base);
            begin
                repeat (40) @(posedge mclk);
                chk({31'h0, link_ready}, 32'h0);
                dma_ready <= 1'b1;
            end
        join
        for (int i = 0; i < 40 && pop_n < 12; i++)
            @(posedge mclk);
        chk(32'(pop_n), 32'd12);
        chk({31'h0, dma_valid}, 32'h0);
    endtask

    task automatic t_irq;
        irq_event <= 1'b1;
        for (int i = 0; i < 10 && irq_out !== 1'b1; i++)
            @(posedge mclk);
        chk({31'h0, irq_out}, 32'h1);
        irq_event <= 1'b0;
        for (int i = 0; i < 10 && irq_out !== 1'b0; i++)
            @(posedge mclk);
        chk({31'h0, irq_out}, 32'h0);
    endtask

    initial
    begin
        srst = 1'b1;
        dma_ready = 1'b0;
        irq_event = 1'b0;
        core_rdata = '0;
        // Link side sees reset through two flops, so traffic waits below
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        repeat (10) @(posedge mclk);
        t_writes;
        t_read;
        t_refuse;
        t_dma;
        t_irq;
        stop_test;
    end
endmodule // esp_eisa_port_test
